// *** shared/rdi_defs.vh ***
// Constants for the register decrement instruction unit
`ifndef RDI_DEFS_VH
`define RDI_DEFS_VH

// ------------------------------------------------------------
// Instruction word layout
// ------------------------------------------------------------
`define RDI_INSTR_W 14
`define RDI_OPC_HI 13
`define RDI_OPC_LO 8
`define RDI_OPC_DECREMENT 6'h03
`define RDI_DEST_BIT 7
`define RDI_IDX_HI 6
`define RDI_IDX_LO 0

// ------------------------------------------------------------
// Destination select encodings
// ------------------------------------------------------------
`define RDI_DEST_ACC 1'h0
`define RDI_DEST_REG 1'h1

// ------------------------------------------------------------
// Status flag layout and reset values
// ------------------------------------------------------------
`define RDI_ZERO_BIT 2
`define RDI_STATUS_RST 8'h00
`define RDI_ACC_RST 8'h00
`define RDI_DATA_RST 8'h00
`define RDI_DEC_STEP 8'h01

// ------------------------------------------------------------
// Sequencer states
// ------------------------------------------------------------
`define RDI_ST_IDLE 2'h0
`define RDI_ST_READ 2'h1
`define RDI_ST_WRITE 2'h2

`endif

// *** hdl/rdi_reg_file.v ***
// Flip-flop register file with one write port and two read ports
`timescale 1ns/1ns
`include "rdi_defs.vh"

module rdi_reg_file #(
	parameter DEPTH = 128,
	parameter ADDR_W = 7,
	parameter DATA_W = 8
) (
	input wire clk,
	input wire rst,
	input wire wrEn,
	input wire [ADDR_W-1:0] wrAddr,
	input wire [DATA_W-1:0] wrData,
	input wire [ADDR_W-1:0] rdAddrA,
	output wire [DATA_W-1:0] rdDataA,
	input wire [ADDR_W-1:0] rdAddrB,
	output wire [DATA_W-1:0] rdDataB
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	wire [DATA_W-1:0] entryQ [0:DEPTH-1];

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1)
		begin : gEntry
			// Index held at the address width so the compare matches bit for bit
			localparam integer CELL_NUM = gi;
			localparam [ADDR_W-1:0] CELL_IDX = CELL_NUM[ADDR_W-1:0];
			reg [DATA_W-1:0] cell_q;
			always @(posedge clk or posedge rst)
			begin
				if (rst)
					cell_q <= `RDI_DATA_RST;
				else if (wrEn && (wrAddr == CELL_IDX))
					cell_q <= wrData;
			end
			assign entryQ[gi] = cell_q;
		end
	endgenerate

	// ------------------------------------------------------------
	// Read ports
	// ------------------------------------------------------------
	// Reads are combinational so the sequencer sees a write on the next cycle
	assign rdDataA = entryQ[rdAddrA];
	assign rdDataB = entryQ[rdAddrB];

endmodule

// *** hdl/rdi_decrement_unit.v ***
// Decode and execute unit for the register decrement operation
//
// Overview of operation
// - Operand holds 7-bit register index 0..127 and one-bit destination select.
// - Read the addressed register, subtract one, deliver result to chosen destination.
// - Destination zero writes the accumulator; the addressed register stays unchanged.
// - Destination one writes the result back into the addressed register.
// - Only the zero flag changes; all other status flags keep their values.
`timescale 1ns/1ns
`include "rdi_defs.vh"

module rdi_decrement_unit #(
	parameter DEPTH = 128,
	parameter ADDR_W = 7,
	parameter DATA_W = 8
) (
	input wire clk,
	input wire rst,
	input wire instrValid,
	input wire [`RDI_INSTR_W-1:0] instrWord,
	input wire accLoadEn,
	input wire [DATA_W-1:0] accLoadData,
	input wire statusLoadEn,
	input wire [DATA_W-1:0] statusLoadData,
	input wire regLoadEn,
	input wire [ADDR_W-1:0] regLoadAddr,
	input wire [DATA_W-1:0] regLoadData,
	input wire [ADDR_W-1:0] regPeekAddr,
	output reg [DATA_W-1:0] regPeekData_q,
	output reg [DATA_W-1:0] acc_q,
	output reg [DATA_W-1:0] status_q,
	output reg [DATA_W-1:0] result_q,
	output reg busy_q,
	output reg done_q,
	output reg reject_q
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire isDecrement;
	wire instrDest;
	wire [ADDR_W-1:0] instrIdx;

	assign isDecrement = (instrWord[`RDI_OPC_HI:`RDI_OPC_LO] == `RDI_OPC_DECREMENT);
	assign instrDest = instrWord[`RDI_DEST_BIT];
	assign instrIdx = instrWord[`RDI_IDX_HI:`RDI_IDX_LO];

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	localparam [1:0] ST_IDLE = `RDI_ST_IDLE;
	localparam [1:0] ST_READ = `RDI_ST_READ;
	localparam [1:0] ST_WRITE = `RDI_ST_WRITE;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg opDest_q;
	reg [ADDR_W-1:0] opIdx_q;
	reg [DATA_W-1:0] operand_q;

	wire [DATA_W-1:0] rfReadData;
	wire [DATA_W-1:0] rfPeekData;
	wire [DATA_W-1:0] decResult;
	wire resultZero;
	wire inIdle;
	wire inRead;
	wire inWrite;
	wire startOp;

	assign inIdle = (state_q == ST_IDLE);
	assign inRead = (state_q == ST_READ);
	assign inWrite = (state_q == ST_WRITE);
	assign startOp = inIdle && instrValid && isDecrement;

	// Eight-bit subtraction drops the borrow, so 8'h00 becomes 8'hff
	assign decResult = operand_q - `RDI_DEC_STEP;
	assign resultZero = (decResult == `RDI_DATA_RST);

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (startOp)
					state_d = ST_READ;
			end
			ST_READ:
			begin
				state_d = ST_WRITE;
			end
			ST_WRITE:
			begin
				state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------
	// Operand capture
	// ------------------------------------------------------------
	// Fields are latched so the instruction bus may change while busy
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			opDest_q <= `RDI_DEST_ACC;
			opIdx_q <= {ADDR_W{1'b0}};
		end
		else if (startOp)
		begin
			opDest_q <= instrDest;
			opIdx_q <= instrIdx;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			operand_q <= `RDI_DATA_RST;
		else if (inRead)
			operand_q <= rfReadData;
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	reg rfWrEn;
	reg [ADDR_W-1:0] rfWrAddr;
	reg [DATA_W-1:0] rfWrData;

	// Preloads are only taken while idle so they never race the write-back
	always @*
	begin
		rfWrEn = 1'b0;
		rfWrAddr = opIdx_q;
		rfWrData = decResult;
		if (inWrite)
		begin
			rfWrEn = (opDest_q == `RDI_DEST_REG);
			rfWrAddr = opIdx_q;
			rfWrData = decResult;
		end
		else if (inIdle && regLoadEn)
		begin
			rfWrEn = 1'b1;
			rfWrAddr = regLoadAddr;
			rfWrData = regLoadData;
		end
	end

	rdi_reg_file #(
		.DEPTH(DEPTH),
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) uRegFile (
		.clk(clk),
		.rst(rst),
		.wrEn(rfWrEn),
		.wrAddr(rfWrAddr),
		.wrData(rfWrData),
		.rdAddrA(opIdx_q),
		.rdDataA(rfReadData),
		.rdAddrB(regPeekAddr),
		.rdDataB(rfPeekData)
	);

	// ------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_q <= `RDI_ACC_RST;
		else if (inWrite && (opDest_q == `RDI_DEST_ACC))
			acc_q <= decResult;
		else if (inIdle && accLoadEn)
			acc_q <= accLoadData;
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// The write-back touches one bit; a preload can change any bit while idle
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			status_q <= `RDI_STATUS_RST;
		else if (inWrite)
			status_q[`RDI_ZERO_BIT] <= resultZero;
		else if (inIdle && statusLoadEn)
			status_q <= statusLoadData;
	end

	// ------------------------------------------------------------
	// Result and handshake outputs
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			result_q <= `RDI_DATA_RST;
		else if (inWrite)
			result_q <= decResult;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			reject_q <= 1'b0;
		end
		else
		begin
			busy_q <= (state_d != ST_IDLE);
			done_q <= inWrite;
			reject_q <= inIdle && instrValid && !isDecrement;
		end
	end

	// ------------------------------------------------------------
	// Register peek port
	// ------------------------------------------------------------
	// One cycle of latency keeps the output straight from a flip-flop
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			regPeekData_q <= `RDI_DATA_RST;
		else
			regPeekData_q <= rfPeekData;
	end

endmodule

// *** tb/rdi_dec_properties.sv ***
// Concurrent checks on the decrement unit ports
`timescale 1ns/1ns
`include "rdi_defs.vh"
module rdi_dec_properties #(
	parameter DATA_W = 8
) (
	input wire clk,
	input wire rst,
	input wire instrValid,
	input wire [`RDI_INSTR_W-1:0] instrWord,
	input wire [DATA_W-1:0] acc_q,
	input wire [DATA_W-1:0] status_q,
	input wire [DATA_W-1:0] result_q,
	input wire busy_q,
	input wire done_q,
	input wire reject_q
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	reg [13:0] iw_q;
	// Keeps the taken word so the write-back can be judged by its target
	always @(posedge clk)
		if (!busy_q && instrValid)
			iw_q <= instrWord;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence takeOp;
		!busy_q && instrValid && instrWord[13:8] == 6'h03;
	endsequence
	sequence runOp;
		busy_q ##1 busy_q ##1 (!busy_q && done_q);
	endsequence
	op_sequence_a: assert property (takeOp |=> runOp) else $error("op run wrong");
	bad_opcode_a: assert property (!busy_q && instrValid && instrWord[13:8] != 6'h03
		|=> reject_q && !busy_q && !done_q) else $error("reject wrong");
	done_after_run_a: assert property (done_q |-> $past(busy_q) && $past(busy_q, 2)) else $error("early done");
	acc_target_a: assert property (done_q && !iw_q[7] |-> acc_q == result_q) else $error("acc miss");
	reg_target_a: assert property (done_q && iw_q[7] |-> $stable(acc_q)) else $error("acc touched");
	other_flags_a: assert property (done_q |-> ((status_q ^ $past(status_q)) & 8'hfb) == 8'h00)
		else $error("flags touched");
	zero_flag_a: assert property (done_q |-> status_q[2] == (result_q == 8'h00)) else $error("zero flag");
endmodule
bind rdi_decrement_unit rdi_dec_properties #(.DATA_W(DATA_W)) chk_u (.clk(clk), .rst(rst),
	.instrValid(instrValid), .instrWord(instrWord), .acc_q(acc_q), .status_q(status_q),
	.result_q(result_q), .busy_q(busy_q), .done_q(done_q), .reject_q(reject_q));

// *** tb/register_decrement_instruction_tb.sv ***
// Self-checking bench for the decrement unit
`timescale 1ns/1ns
module register_decrement_instruction_tb;
	reg clk, rst, instrValid, accLoadEn, statusLoadEn, regLoadEn;
	reg [13:0] instrWord;
	reg [7:0] accLoadData, statusLoadData, regLoadData, mAcc, mSt, mRes;
	reg [6:0] regLoadAddr, regPeekAddr;
	wire [7:0] regPeekData_q, acc_q, status_q, result_q;
	wire busy_q, done_q, reject_q;
	reg [7:0] mem [0:127];
	logic [24:0] expQ[$];
	int error_cnt = 0;
	int samples_checked = 0;
	rdi_decrement_unit dut_u (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
		.accLoadEn(accLoadEn), .accLoadData(accLoadData), .statusLoadEn(statusLoadEn),
		.statusLoadData(statusLoadData), .regLoadEn(regLoadEn), .regLoadAddr(regLoadAddr),
		.regLoadData(regLoadData), .regPeekAddr(regPeekAddr), .regPeekData_q(regPeekData_q),
		.acc_q(acc_q), .status_q(status_q), .result_q(result_q), .busy_q(busy_q), .done_q(done_q),
		.reject_q(reject_q));
	always #50 clk = ~clk;
	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task chk_res(input [24:0] got, input [24:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_peek(input [7:0] got, input [7:0] exp);
		chk_res({17'h0, got}, {17'h0, exp});
	endtask
	task give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task load(input [6:0] a, input [7:0] d, input [7:0] ac, input [7:0] s);
		{regLoadEn, accLoadEn, statusLoadEn} = 3'h7;
		{regLoadAddr, regLoadData, accLoadData, statusLoadData} = {a, d, ac, s};
		mem[a] = d;
		mAcc = ac;
		mSt = s;
		@(negedge clk);
		{regLoadEn, accLoadEn, statusLoadEn} = 3'h0;
	endtask
	// Model updated at issue; the monitor sees the note long before done
	task op(input [5:0] opc, input d, input [6:0] a);
		reg [7:0] r;
		int n;
		r = mem[a] - 8'h01;
		if (opc != 6'h03)
			expQ.push_back({1'b1, mRes, mAcc, mSt});
		else
		begin
			if (d)
				mem[a] = r;
			else
				mAcc = r;
			mSt[2] = (r == 8'h00);
			mRes = r;
			expQ.push_back({1'b0, r, mAcc, mSt});
		end
		instrValid = 1'b1;
		instrWord = {opc, d, a};
		@(negedge clk);
		instrValid = 1'b0;
		n = 0;
		while (busy_q !== 1'b0 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		if (busy_q !== 1'b0)
		begin
			error_cnt++;
			$display("BAD %0t hang", $time);
			give_verdict;
		end
	endtask
	task peek(input [6:0] a);
		regPeekAddr = a;
		@(negedge clk);
		chk_peek(regPeekData_q, mem[a]);
	endtask
	always @(negedge clk)
		if (!rst && (done_q === 1'b1 || reject_q === 1'b1))
			chk_res({reject_q, result_q, acc_q, status_q}, expQ.size() ? expQ.pop_front() : 25'h1ffffff);
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		logic [6:0] a;
		logic [7:0] dv;
		{clk, rst, instrValid, accLoadEn, statusLoadEn, regLoadEn} = 6'h10;
		{instrWord, accLoadData, statusLoadData, regLoadData, regLoadAddr, regPeekAddr} = 0;
		{mAcc, mSt, mRes} = 0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'h00;
		void'($urandom(32'h267a));
		repeat (2) @(negedge clk);
		rst = 1'b0;
		peek(7'h7f);
		for (int i = 0; i < 16; i++)
		begin
			a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
			dv = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h01 : 8'($urandom);
			load(a, dv, 8'($urandom), 8'($urandom));
			op((i % 5 == 4) ? 6'h04 + 6'(i) : 6'h03, i[0], a);
			peek(a);
		end
		$display("test mixed done");
		// Back to back on one register crosses zero and wraps
		load(7'h2a, 8'h02, 8'h55, 8'hff);
		for (int j = 0; j < 4; j++)
			op(6'h03, 1'b1, 7'h2a);
		op(6'h03, 1'b0, 7'h2a);
		peek(7'h2a);
		$display("test chain done");
		repeat (4) @(negedge clk);
		chk_peek(8'(expQ.size()), 8'h00);
		give_verdict;
	end
endmodule
